// ===== shared/rtc_map.svh
// register offsets, field positions, reset values and timing figures of the rtc core
// included by the time counters and the core, not by the synchroniser; holds definitions only
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH

`define REG_SEC         5'h00
`define REG_MIN         5'h01
`define REG_HOUR        5'h02
`define REG_DAY         5'h03
`define REG_DATE        5'h04
`define REG_MON         5'h05
`define REG_YEAR        5'h06
`define REG_ALM_FIRST   5'h07
`define REG_ALM_LAST    5'h0d
`define REG_CTRL        5'h0e
`define REG_STAT        5'h0f
`define REG_TRICKLE     5'h10
`define REG_LAST        5'h10
`define PTR_STEP        5'h01
`define NUM_ALM_REGS    7

`define CTRL_RST        8'h04
`define STAT_RST        8'h80
`define TRICKLE_RST     8'h00
`define ALM_RST         8'h00
`define RD_UNMAPPED     8'h00

`define CTRL_EOSC_BIT   7
`define CTRL_RS2_BIT    4
`define CTRL_RS1_BIT    3
`define CTRL_INTCN_BIT  2
`define CTRL_A2IE_BIT   1
`define CTRL_A1IE_BIT   0
`define STAT_A2F_BIT    1
`define STAT_A1F_BIT    0
`define STAT_A1F_MASK   8'h01
`define STAT_A2F_MASK   8'h02
`define HR_12H_BIT      6
`define HR_PM_BIT       5
`define MON_CENT_BIT    7
`define ALM_MASK_BIT    7
`define ALM_DYDT_BIT    6

`define BCD_DIGIT_9     4'h9
`define BCD_00          8'h00
`define BCD_01          8'h01
`define BCD_07          8'h07
`define BCD_28          8'h28
`define BCD_29          8'h29
`define BCD_30          8'h30
`define BCD_31          8'h31
`define BCD_59          8'h59
`define BCD_99          8'h99
`define HR12_01         5'h01
`define HR12_11         5'h11
`define HR12_12         5'h12
`define HR24_23         6'h23
`define MON_FEB         5'h02
`define MON_APR         5'h04
`define MON_JUN         5'h06
`define MON_SEP         5'h09
`define MON_NOV         5'h11
`define MON_DEC         5'h12

`define XTAL_HZ         32768
`define PRESC_W         15
`define SQW_1HZ_TAP     14
`define SQW_4K_TAP      2
`define SQW_8K_TAP      1
`define RS_1HZ          2'b00
`define RS_4K           2'b01
`define RS_8K           2'b10
`define BITS_PER_BYTE   4'h8

`endif

// ===== shared/rtc_pkg.sv
// types shared by the rtc core files
// no dependencies
package rtc_pkg;

  typedef logic [7:0] bcd_byte_t;

  // index 0 is seconds, index 6 is year
  typedef logic [6:0][7:0] time_regs_t;

  typedef enum {
    S_IDLE,
    S_RX,
    S_RXACK,
    S_TX,
    S_TXACK
  } bus_state_t;

endpackage

// ===== verilog/rtc_sync.sv
// two-flop synchroniser with edge pulses for a group of asynchronous inputs
// assumes inputs are slow against clock_i; outputs follow inputs by one to two cycles
`timescale 1ns/1ns
module rtc_sync import rtc_pkg::*; #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             resetn_i,
  // asynchronous levels
  input  wire logic [WIDTH-1:0] async_i,
  // synchronised level and one-cycle edge pulses
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] rise_o,
  output logic      [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] prev_r;

  // meta_r feeds sync_r only
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level_o = sync_r;
  assign rise_o  = sync_r & ~prev_r;
  assign fall_o  = ~sync_r & prev_r;

endmodule // rtc_sync

// ===== verilog/rtc_time.sv
// bcd time and calendar counters with host write port
// assumes tick_i is a one-cycle pulse once per second; a write wins over a tick
`timescale 1ns/1ns
`include "rtc_map.svh"
module rtc_time import rtc_pkg::*; (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  // one-second pulse
  input  wire logic       tick_i,
  // register writes
  input  wire logic       wr_en_i,
  input  wire logic [4:0] wr_addr_i,
  input  wire bcd_byte_t  wr_data_i,
  // live time
  output time_regs_t      time_o
);

  bcd_byte_t sec_r, min_r, hr_r, day_r, date_r, mon_r, yr_r;

  function automatic bcd_byte_t bcd_inc(input bcd_byte_t v);
    bcd_inc = (v[3:0] == `BCD_DIGIT_9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  wire bcd_byte_t  sec_inc  = bcd_inc(sec_r);
  wire bcd_byte_t  min_inc  = bcd_inc(min_r);
  wire bcd_byte_t  hr12_inc = bcd_inc({3'b000, hr_r[4:0]});
  wire bcd_byte_t  hr24_inc = bcd_inc({2'b00, hr_r[5:0]});
  wire bcd_byte_t  date_inc = bcd_inc(date_r);
  wire bcd_byte_t  mon_inc  = bcd_inc({3'b000, mon_r[4:0]});
  wire bcd_byte_t  yr_inc   = bcd_inc(yr_r);
  wire logic [4:0] mon_f    = mon_r[4:0];
  wire logic       hr12     = hr_r[`HR_12H_BIT];
  wire logic       pm       = hr_r[`HR_PM_BIT];

  // units digit multiple of four with even tens, or two mod four with odd tens
  wire logic       leap     = (yr_r[1:0] == {yr_r[4], 1'b0});
  wire logic       short30  = (mon_f == `MON_APR) || (mon_f == `MON_JUN) ||
                              (mon_f == `MON_SEP) || (mon_f == `MON_NOV);
  wire bcd_byte_t  mlen     = (mon_f == `MON_FEB) ? (leap ? `BCD_29 : `BCD_28) :
                              (short30 ? `BCD_30 : `BCD_31);

  wire logic sec_end  = (sec_r == `BCD_59);
  wire logic min_end  = (min_r == `BCD_59);
  wire logic day_end  = hr12 ? (pm && hr_r[4:0] == `HR12_11) : (hr_r[5:0] == `HR24_23);
  wire logic date_end = (date_r == mlen);
  wire logic mon_end  = (mon_f == `MON_DEC);
  wire logic yr_end   = (yr_r == `BCD_99);

  wire logic step_min  = tick_i & sec_end;
  wire logic step_hr   = step_min & min_end;
  wire logic step_day  = step_hr & day_end;
  wire logic step_mon  = step_day & date_end;
  wire logic step_yr   = step_mon & mon_end;

  // 12-hour: 11 flips am/pm into 12, 12 goes to 01; 24-hour: 23 goes to 00
  wire bcd_byte_t hr_next = hr12 ?
    ((hr_r[4:0] == `HR12_11) ? {2'b01, ~pm, `HR12_12} :
     (hr_r[4:0] == `HR12_12) ? {2'b01, pm, `HR12_01} : {2'b01, pm, hr12_inc[4:0]}) :
    (day_end ? `BCD_00 : {2'b00, hr24_inc[5:0]});

  // month field only; the century bit is kept above it and toggles at every December->January rollover
  wire logic [4:0] mon_next = mon_end ? 5'(`BCD_01) : mon_inc[4:0];

  wire logic wr_sec  = wr_en_i && (wr_addr_i == `REG_SEC);
  wire logic wr_min  = wr_en_i && (wr_addr_i == `REG_MIN);
  wire logic wr_hr   = wr_en_i && (wr_addr_i == `REG_HOUR);
  wire logic wr_day  = wr_en_i && (wr_addr_i == `REG_DAY);
  wire logic wr_date = wr_en_i && (wr_addr_i == `REG_DATE);
  wire logic wr_mon  = wr_en_i && (wr_addr_i == `REG_MON);
  wire logic wr_yr   = wr_en_i && (wr_addr_i == `REG_YEAR);

  // all counting is in bcd; registers persist regardless of supply state
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      sec_r  <= `BCD_00;
      min_r  <= `BCD_00;
      hr_r   <= `BCD_00;
      day_r  <= `BCD_01;
      date_r <= `BCD_01;
      mon_r  <= `BCD_01;
      yr_r   <= `BCD_00;
    end else begin
      if (wr_sec) sec_r <= wr_data_i;
      else if (tick_i) sec_r <= sec_end ? `BCD_00 : sec_inc;
      if (wr_min) min_r <= wr_data_i;
      else if (step_min) min_r <= min_end ? `BCD_00 : min_inc;
      if (wr_hr) hr_r <= wr_data_i;
      else if (step_hr) hr_r <= hr_next;
      if (wr_day) day_r <= wr_data_i;
      else if (step_day) day_r <= (day_r == `BCD_07) ? `BCD_01 : bcd_inc(day_r);
      if (wr_date) date_r <= wr_data_i;
      else if (step_day) date_r <= date_end ? `BCD_01 : date_inc;
      if (wr_mon) mon_r <= wr_data_i;
      else if (step_mon) mon_r <= {mon_r[`MON_CENT_BIT] ^ step_yr, 2'b00, mon_next};
      if (wr_yr) yr_r <= wr_data_i;
      else if (step_yr) yr_r <= yr_end ? `BCD_00 : yr_inc;
    end
  end

  assign time_o = {yr_r, mon_r, date_r, day_r, hr_r, min_r, sec_r};

endmodule // rtc_time

// ===== verilog/serial_rtc_calendar_core.sv
// two-wire serial real-time clock core: bus slave, register file, alarms, square wave
// assumes scl/sda/crystal/power-fail are asynchronous pins; open-drain wires resolved outside
//
// Overview of operation
// - Seconds, minutes, hours, day, date, month and year are counted and all can be read.
// - The date rolls over at each month's length, with 30-day months and leap-year February.
// - Hours run in 24-hour or 12-hour format, the latter with an am/pm indicator.
// - Two programmable time-of-day alarms are compared against the running time.
// - The core is only a slave; each access starts with START, the device code, then data.
// - After the first register each further byte steps to the next one until STOP.
// - Access is allowed while supply is good and all register access is blocked below threshold.
// - On backup supply register contents are kept, and timekeeping too unless control bit 7 (EOSC) is set.
// - The square-wave/interrupt pin carries a square wave or an interrupt and only pulls low.
// - The data line is only pulled low or released, never driven high.
// - The one-second base is divided from the 32.768 kHz reference on the crystal input.
// - The register pointer wraps from the last register back to the first.
// - START, STOP or a pointer wrap copies the live time into a shadow set that reads use.
// - Time and date are held and counted in bcd.
// - Hours bit 6 high selects 12-hour mode with bit 5 as pm, else bit 5 is a tens-of-hours bit.
`timescale 1ns/1ns
`include "rtc_map.svh"
module serial_rtc_calendar_core import rtc_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = 7'h2a   // arbitrary device code
) (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic resetn_i,
  // two-wire bus
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oen_o,
  // time base and supply sense
  input  wire logic crystal_in_i,
  input  wire logic power_fail_i,
  // open-drain square wave / interrupt
  output logic      square_wave_irq_out_o,
  output logic      square_wave_irq_out_oen_o
);

  localparam logic [`PRESC_W-1:0] PRESC_LAST = `PRESC_W'(`XTAL_HZ - 1);

  // synchronised pins
  logic [3:0] pin_lvl;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;

  rtc_sync #(
    .WIDTH   (4)
  ) u_sync (
    .clock_i (clock_i),
    .resetn_i(resetn_i),
    .async_i ({power_fail_i, crystal_in_i, sda_i, scl_i}),
    .level_o (pin_lvl),
    .rise_o  (pin_rise),
    .fall_o  (pin_fall)
  );

  wire logic scl_lvl   = pin_lvl[0];
  wire logic scl_rise  = pin_rise[0];
  wire logic scl_fall  = pin_fall[0];
  wire logic sda_lvl   = pin_lvl[1];
  wire logic xtal_lvl  = pin_lvl[2];
  wire logic xtal_rise = pin_rise[2];
  wire logic pf_lvl    = pin_lvl[3];

  // start and stop: data moves while clock is high
  wire logic bus_start = pin_fall[1] & scl_lvl;
  wire logic bus_stop  = pin_rise[1] & scl_lvl;

  // state
  bus_state_t          state_r, state_nxt;
  logic [3:0]          bit_cnt_r, bit_cnt_nxt;
  bcd_byte_t           shift_r, shift_nxt;
  logic [4:0]          ptr_r, ptr_nxt;
  logic                rw_r, rw_nxt;
  logic                addr_ph_r, addr_ph_nxt;
  logic                got_ptr_r, got_ptr_nxt;
  logic                sda_oen_r, sda_oen_nxt;
  logic                wr_en;
  logic                ptr_adv;
  logic [`PRESC_W-1:0] presc_r;
  logic                tick_d_r;
  logic                sqw_oen_r;
  bcd_byte_t           ctrl_r;
  bcd_byte_t           stat_r;
  bcd_byte_t           trickle_r;
  bcd_byte_t           alm_r [`NUM_ALM_REGS];
  time_regs_t          time_v;
  time_regs_t          shadow_r;

  // oscillator may be stopped by software only while on backup supply
  wire logic osc_run  = ~(ctrl_r[`CTRL_EOSC_BIT] & pf_lvl);
  wire logic sec_tick = xtal_rise & osc_run & (presc_r == PRESC_LAST);

  // pointer stepping and wrap
  wire logic       ptr_wrap = (ptr_r == `REG_LAST);
  wire logic [4:0] ptr_step = ptr_wrap ? `REG_SEC : ptr_r + `PTR_STEP;
  wire logic       byte_end = (bit_cnt_r == `BITS_PER_BYTE);
  wire logic       addr_hit = (shift_r[7:1] == DEV_ADDR);
  wire logic       snap     = bus_start | bus_stop | (ptr_adv & ptr_wrap);
  wire logic       wr_seconds = wr_en && (ptr_r == `REG_SEC);

  // read selection: time from the shadow copy, the rest live
  wire logic       in_time = (ptr_r < `REG_ALM_FIRST);
  wire logic       in_alm  = (ptr_r <= `REG_ALM_LAST);
  wire logic [4:0] alm_idx = ptr_r - `REG_ALM_FIRST;
  wire bcd_byte_t  rd_byte = in_time ? shadow_r[ptr_r[2:0]] :
                             in_alm ? alm_r[alm_idx[2:0]] :
                             (ptr_r == `REG_CTRL) ? ctrl_r :
                             (ptr_r == `REG_STAT) ? stat_r :
                             (ptr_r == `REG_TRICKLE) ? trickle_r : `RD_UNMAPPED;

  rtc_time u_time (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .tick_i   (sec_tick),
    .wr_en_i  (wr_en),
    .wr_addr_i(ptr_r),
    .wr_data_i(shift_r),
    .time_o   (time_v)
  );

  // bus engine: sample on scl rise, change sda on scl fall
  always_comb begin
    state_nxt   = state_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt   = shift_r;
    ptr_nxt     = ptr_r;
    rw_nxt      = rw_r;
    addr_ph_nxt = addr_ph_r;
    got_ptr_nxt = got_ptr_r;
    sda_oen_nxt = sda_oen_r;
    wr_en       = 1'b0;
    ptr_adv     = 1'b0;
    if (bus_start) begin
      state_nxt   = S_RX;
      bit_cnt_nxt = 4'h0;
      addr_ph_nxt = 1'b1;
      got_ptr_nxt = 1'b0;
      sda_oen_nxt = 1'b1;
    end else if (bus_stop) begin
      state_nxt   = S_IDLE;
      sda_oen_nxt = 1'b1;
    end else begin
      case (state_r)
        S_IDLE: begin
          sda_oen_nxt = 1'b1;
        end
        S_RX: begin
          if (scl_rise) begin
            shift_nxt   = {shift_r[6:0], sda_lvl};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (scl_fall && byte_end) begin
            if (pf_lvl) begin
              state_nxt = S_IDLE;
            end else if (addr_ph_r) begin
              if (addr_hit) begin
                rw_nxt      = shift_r[0];
                state_nxt   = S_RXACK;
                sda_oen_nxt = 1'b0;
              end else begin
                state_nxt = S_IDLE;
              end
            end else begin
              state_nxt   = S_RXACK;
              sda_oen_nxt = 1'b0;
              if (!got_ptr_r) begin
                ptr_nxt     = shift_r[4:0];
                got_ptr_nxt = 1'b1;
              end else begin
                wr_en   = 1'b1;
                ptr_adv = 1'b1;
                ptr_nxt = ptr_step;
              end
            end
          end
        end
        S_RXACK: begin
          if (scl_fall) begin
            addr_ph_nxt = 1'b0;
            bit_cnt_nxt = 4'h0;
            if (addr_ph_r && rw_r) begin
              state_nxt   = S_TX;
              shift_nxt   = rd_byte;
              sda_oen_nxt = rd_byte[7];
            end else begin
              state_nxt   = S_RX;
              sda_oen_nxt = 1'b1;
            end
          end
        end
        S_TX: begin
          if (pf_lvl) begin
            state_nxt   = S_IDLE;
            sda_oen_nxt = 1'b1;
          end else if (scl_rise) begin
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (byte_end) begin
              state_nxt   = S_TXACK;
              sda_oen_nxt = 1'b1;
              ptr_adv     = 1'b1;
              ptr_nxt     = ptr_step;
            end else begin
              shift_nxt   = {shift_r[6:0], 1'b0};
              sda_oen_nxt = shift_r[6];
            end
          end
        end
        S_TXACK: begin
          if (scl_rise && sda_lvl) begin
            state_nxt = S_IDLE;
          end else if (scl_fall) begin
            state_nxt   = S_TX;
            bit_cnt_nxt = 4'h0;
            shift_nxt   = rd_byte;
            sda_oen_nxt = rd_byte[7];
          end
        end
        default: begin
          state_nxt   = S_IDLE;
          sda_oen_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_r   <= S_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r   <= `BCD_00;
      ptr_r     <= `REG_SEC;
      rw_r      <= 1'b0;
      addr_ph_r <= 1'b0;
      got_ptr_r <= 1'b0;
      sda_oen_r <= 1'b1;
    end else begin
      state_r   <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r   <= shift_nxt;
      ptr_r     <= ptr_nxt;
      rw_r      <= rw_nxt;
      addr_ph_r <= addr_ph_nxt;
      got_ptr_r <= got_ptr_nxt;
      sda_oen_r <= sda_oen_nxt;
    end
  end

  // shadow copy keeps a multi-byte read coherent while counting goes on
  always_ff @(posedge clock_i) begin
    if (!resetn_i) shadow_r <= '0;
    else if (snap) shadow_r <= time_v;
  end

  // divide the synchronised reference down to one second; a seconds write restarts it
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      presc_r  <= '0;
      tick_d_r <= 1'b0;
    end else begin
      tick_d_r <= sec_tick;
      if (wr_seconds) presc_r <= '0;
      else if (xtal_rise && osc_run) presc_r <= presc_r + `PRESC_W'(1);
    end
  end

  // alarm bytes, one register per entry
  genvar g;
  generate
    for (g = 0; g < `NUM_ALM_REGS; g++) begin : g_alm
      always_ff @(posedge clock_i) begin
        if (!resetn_i) alm_r[g] <= `ALM_RST;
        else if (wr_en && ptr_r == `REG_ALM_FIRST + 5'(g)) alm_r[g] <= shift_r;
      end
    end
  endgenerate

  // alarm compare one cycle after the tick, once the counters have settled
  wire logic a1_sec  = alm_r[0][`ALM_MASK_BIT] | (alm_r[0][6:0] == time_v[0][6:0]);
  wire logic a1_min  = alm_r[1][`ALM_MASK_BIT] | (alm_r[1][6:0] == time_v[1][6:0]);
  wire logic a1_hr   = alm_r[2][`ALM_MASK_BIT] | (alm_r[2][6:0] == time_v[2][6:0]);
  wire logic a1_dd   = alm_r[3][`ALM_MASK_BIT] | (alm_r[3][`ALM_DYDT_BIT] ?
                       (alm_r[3][3:0] == time_v[3][3:0]) : (alm_r[3][5:0] == time_v[4][5:0]));
  wire logic a2_min  = alm_r[4][`ALM_MASK_BIT] | (alm_r[4][6:0] == time_v[1][6:0]);
  wire logic a2_hr   = alm_r[5][`ALM_MASK_BIT] | (alm_r[5][6:0] == time_v[2][6:0]);
  wire logic a2_dd   = alm_r[6][`ALM_MASK_BIT] | (alm_r[6][`ALM_DYDT_BIT] ?
                       (alm_r[6][3:0] == time_v[3][3:0]) : (alm_r[6][5:0] == time_v[4][5:0]));
  wire logic a1_hit  = tick_d_r & a1_sec & a1_min & a1_hr & a1_dd;
  wire logic a2_hit  = tick_d_r & (time_v[0] == `BCD_00) & a2_min & a2_hr & a2_dd;
  wire bcd_byte_t stat_set = ({8{a1_hit}} & `STAT_A1F_MASK) | ({8{a2_hit}} & `STAT_A2F_MASK);
  wire logic wr_ctrl = wr_en && (ptr_r == `REG_CTRL);
  wire logic wr_stat = wr_en && (ptr_r == `REG_STAT);
  wire logic wr_trkl = wr_en && (ptr_r == `REG_TRICKLE);

  // flags clear only where a zero is written; a same-cycle alarm still sets
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ctrl_r    <= `CTRL_RST;
      stat_r    <= `STAT_RST;
      trickle_r <= `TRICKLE_RST;
    end else begin
      if (wr_ctrl) ctrl_r <= shift_r;
      if (wr_trkl) trickle_r <= shift_r;
      stat_r <= (wr_stat ? (stat_r & shift_r) : stat_r) | stat_set;
    end
  end

  // square wave or interrupt, pin only ever pulled low
  wire logic [1:0] rate    = ctrl_r[`CTRL_RS2_BIT:`CTRL_RS1_BIT];
  wire logic       sq_bit  = (rate == `RS_1HZ) ? presc_r[`SQW_1HZ_TAP] :
                             (rate == `RS_4K) ? presc_r[`SQW_4K_TAP] :
                             (rate == `RS_8K) ? presc_r[`SQW_8K_TAP] : xtal_lvl;
  wire logic       irq     = (stat_r[`STAT_A1F_BIT] & ctrl_r[`CTRL_A1IE_BIT]) |
                             (stat_r[`STAT_A2F_BIT] & ctrl_r[`CTRL_A2IE_BIT]);
  wire logic       pin_rel = ctrl_r[`CTRL_INTCN_BIT] ? ~irq : (sq_bit & osc_run);

  always_ff @(posedge clock_i) begin
    if (!resetn_i) sqw_oen_r <= 1'b1;
    else sqw_oen_r <= pin_rel;
  end

  assign sda_o                     = 1'b0;
  assign sda_oen_o                 = sda_oen_r;
  assign square_wave_irq_out_o     = 1'b0;
  assign square_wave_irq_out_oen_o = sqw_oen_r;

endmodule // serial_rtc_calendar_core

// ===== dv/rtc_checker.sv
// pin assertions for serial_rtc_calendar_core
// bound into the core; sees only its ports
`timescale 1ns/1ns
module rtc_checker (
  // watched pins
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oen_o,
  input wire logic power_fail_i,
  input wire logic square_wave_irq_out_o,
  input wire logic square_wave_irq_out_oen_o
);
  logic [3:0] pf_cnt_r;
  logic [3:0] hi_cnt_r;
  // saturating run lengths of power fail and of bus clock high
  always_ff @(posedge clock_i) begin
    pf_cnt_r <= (!resetn_i || !power_fail_i) ? 4'h0 : pf_cnt_r + {3'h0, pf_cnt_r != 4'hf};
    hi_cnt_r <= (!resetn_i || !scl_i) ? 4'h0 : hi_cnt_r + {3'h0, hi_cnt_r != 4'hf};
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  a_sda_low_only: assert property (sda_o == 1'b0) else $error("data pin driven high");
  a_irq_low_only: assert property (square_wave_irq_out_o == 1'b0) else $error("irq pin driven high");
  a_reset_releases: assert property (@(posedge clock_i) disable iff (1'b0)
    !resetn_i |=> sda_oen_o && square_wave_irq_out_oen_o) else $error("pins not released in reset");
  a_irq_idle_after: assert property ($rose(resetn_i) |-> square_wave_irq_out_oen_o [*8])
    else $error("irq pin active after reset");
  a_fail_blocks_bus: assert property (pf_cnt_r == 4'hf |-> sda_oen_o)
    else $error("bus driven during power fail");
  a_drive_whole_bit: assert property ($fell(sda_oen_o) |=> !sda_oen_o [*4])
    else $error("data drive too short");
  a_hold_scl_high: assert property (scl_i [*4] |-> $stable(sda_oen_o))
    else $error("data changed while bus clock high");
  a_idle_released: assert property (hi_cnt_r >= 4'hc |-> sda_oen_o)
    else $error("data driven while bus idle");
endmodule // rtc_checker
bind serial_rtc_calendar_core rtc_checker rtc_checker_i (.clock_i, .resetn_i, .scl_i, .sda_o, .sda_oen_o,
  .power_fail_i, .square_wave_irq_out_o, .square_wave_irq_out_oen_o);

// ===== dv/host.sv
// two-wire bus master model facing the core
// pins change after the falling clock edge; one bus clock is 8 cycles
`timescale 1ns/1ns
module host (
  input  wire logic       clock_i,
  input  wire logic       sda_i,
  output logic            scl_o,
  output logic            sda_drv_o,
  output logic      [7:0] res_o,
  output logic            res_tgl_o
);
  initial begin
    scl_o = 1'b1;
    sda_drv_o = 1'b1;
    res_o = 8'h00;
    res_tgl_o = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  // data moves mid-low so that no false start or stop is seen
  task automatic bit_io(input logic b, output logic s);
    gap(2);
    sda_drv_o = b;
    gap(2);
    scl_o = 1'b1;
    gap(4);
    s = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic edge_pair(input logic a, input logic b);
    gap(2);
    sda_drv_o = a;
    gap(2);
    scl_o = 1'b1;
    gap(4);
    sda_drv_o = b;
    gap(4);
  endtask
  task automatic start();
    edge_pair(1'b1, 1'b0);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    edge_pair(1'b0, 1'b1);
  endtask
  // a write returns the ack bit, a read the byte; nack ends a read
  task automatic xfer(input logic [7:0] d, input logic rd, input logic nack);
    logic [7:0] r;
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(rd | d[i], r[i]);
    bit_io(rd ? nack : 1'b1, a);
    res_o = rd ? r : {7'h00, a};
    res_tgl_o = ~res_tgl_o;
  endtask
endmodule // host

// ===== dv/serial_rtc_calendar_core_tb.sv
// self-checking bench: host model on the bus, results compared from a queue
// the run's only second is timed near the end, to check rollover and alarm
`timescale 1ns/1ns
module serial_rtc_calendar_core_tb import rtc_pkg::*;;
  localparam logic [6:0] DEV = 7'h2a; // arbitrary device code
  logic clock, resetn, pf, xtal, scl, m_sda, oen, tgl, sda, irq_oen;
  logic [7:0] res;
  bcd_byte_t q[$];
  bcd_byte_t tv[7];
  int fail_count, comparisons, seed;
  assign sda = m_sda & oen;
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(negedge clock) xtal <= ~xtal;
  serial_rtc_calendar_core #(.DEV_ADDR(DEV)) serial_rtc_calendar_core_i (.clock_i(clock), .resetn_i(resetn),
    .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oen_o(oen), .crystal_in_i(xtal), .power_fail_i(pf),
    .square_wave_irq_out_o(), .square_wave_irq_out_oen_o(irq_oen));
  host host_i (.clock_i(clock), .sda_i(sda), .scl_o(scl), .sda_drv_o(m_sda), .res_o(res), .res_tgl_o(tgl));
  task automatic finish_test();
    $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wb(input logic [7:0] d, input logic [7:0] e);
    q.push_back(e);
    host_i.xfer(d, 1'b0, 1'b0);
  endtask
  task automatic rb(input logic [7:0] e, input logic last);
    q.push_back(e);
    host_i.xfer(8'hff, 1'b1, last);
  endtask
  // set the pointer; for reads follow with a repeated start
  task automatic sel(input logic [7:0] p, input logic rd);
    host_i.start();
    wb({DEV, 1'b0}, 8'h00);
    wb(p, 8'h00);
    if (rd) begin
      host_i.start();
      wb({DEV, 1'b1}, 8'h00);
    end
  endtask
  initial begin : monitor
    bcd_byte_t e;
    forever begin
      @(tgl);
      comparisons++;
      e = q.pop_front();
      if (res !== e) begin
        $display("unexpected result byte: expected %h seen %h", e, res);
        fail_count++;
      end
    end
  end
  initial begin
    repeat (100000) @(posedge clock);
    fail_count++;
    finish_test();
  end
  initial begin
    seed = 32'h72e4;
    resetn = 1'b0;
    pf = 1'b0;
    xtal = 1'b0;
    repeat (10) @(negedge clock);
    resetn = 1'b1;
    repeat (4) @(negedge clock);
    sel(8'h0e, 1'b1);
    rb(8'h04, 1'b0);
    rb(8'h80, 1'b1);
    host_i.stop();
    tv = '{8'h00, 8'h59, 8'h71, 8'h07, 8'h29, 8'h02, 8'h24};
    tv[0][6:4] = 3'($unsigned($random(seed)) % 6);
    tv[0][3:0] = 4'($unsigned($random(seed)) % 10);
    sel(8'h00, 1'b0);
    for (int i = 0; i < 7; i++) wb(tv[i], 8'h00);
    host_i.stop();
    sel(8'h00, 1'b1);
    for (int i = 0; i < 7; i++) rb(tv[i], i == 6);
    host_i.stop();
    sel(8'h10, 1'b0);
    wb(8'ha5, 8'h00);
    wb(8'h33, 8'h00);
    host_i.stop();
    sel(8'h10, 1'b1);
    rb(8'ha5, 1'b0);
    rb(8'h33, 1'b1);
    host_i.stop();
    host_i.start();
    wb({DEV ^ 7'h01, 1'b0}, 8'h01);
    host_i.stop();
    pf = 1'b1;
    repeat (8) @(negedge clock);
    host_i.start();
    wb({DEV, 1'b0}, 8'h01);
    host_i.stop();
    pf = 1'b0;
    repeat (8) @(negedge clock);
    sel(8'h01, 1'b1);
    rb(8'h59, 1'b1);
    host_i.stop();
    // alarm 1 fully masked fires on every second; interrupt mode with its enable set
    sel(8'h07, 1'b0);
    for (int i = 0; i < 8; i++) wb((i < 4) ? 8'h80 : ((i == 7) ? 8'h05 : 8'h00), 8'h00);
    host_i.stop();
    sel(8'h00, 1'b0);
    wb(8'h59, 8'h00);
    host_i.stop();
    // one second is 32768 reference rises, two clocks each, counted from the seconds write
    repeat (66000) @(negedge clock);
    tv = '{8'h00, 8'h00, 8'h52, 8'h01, 8'h01, 8'h03, 8'h24};
    sel(8'h00, 1'b1);
    for (int i = 0; i < 7; i++) rb(tv[i], i == 6);
    host_i.stop();
    sel(8'h0f, 1'b1);
    rb(8'h81, 1'b1);
    host_i.stop();
    comparisons++;
    if (irq_oen !== 1'b0) begin
      $display("unexpected irq pin enable: expected 0 seen %b", irq_oen);
      fail_count++;
    end
    finish_test();
  end
endmodule // serial_rtc_calendar_core_tb
